// ---- rtl/fpe_ctrl.v ----
// flash program/erase sequencer with wishbone register access
// assumes the array and charge pump sit outside on the fl_* ports,
// and that prot_value_i is the array's protect byte on this clock
//
// Operation
// - erased bits read one, programmed bits read zero; zeros get programmed
// - array in 64-byte pages of two 32-byte rows
// - high voltage enable accepted only with a select and proper steps
// - pump and array high voltage follow the high voltage enable bit
// - bulk select one gives whole-array erase, zero gives page erase
// - program and erase selects never both one; such writes refused
// - pages are 64-byte aligned; vector area is one page
// - bulk erase refused when protect byte is not all ones
// - program rows are 32-byte aligned
// - writes of one program cycle stay in one row, else cycle fails
// - after program select and protect read, a data write latches the address; then steps and waits
// - unrelated bus accesses between steps do not disturb a sequence
// - protected address blocks high voltage enable
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "fpe_defs.vh"

module fpe_ctrl #(
    parameter AW = 18
) (
    input  wire          clk_i,
    input  wire          rst_i,
    // wishbone classic slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [AW-1:0] wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output wire [31:0]   wb_dat_o,
    output wire          wb_ack_o,
    // flash array and charge pump
    input  wire [7:0]    prot_value_i,
    input  wire [7:0]    fl_rdata_i,
    output wire [15:0]   fl_addr_o,
    output wire [7:0]    fl_wdata_o,
    output wire          fl_prog_o,
    output wire          fl_erase_page_o,
    output wire          fl_erase_bulk_o,
    output wire          hv_en_o
);

    // ***************************************************************
    // sequence states
    // ***************************************************************
    localparam [4:0] ST_IDLE  = 5'b00001;
    localparam [4:0] ST_SEL   = 5'b00010;
    localparam [4:0] ST_ARMED = 5'b00100;
    localparam [4:0] ST_LATCH = 5'b01000;
    localparam [4:0] ST_HV    = 5'b10000;

    localparam ROW_LSB  = 5;

    // ***************************************************************
    // registers
    // ***************************************************************
    reg         ack_reg;
    reg  [31:0] rdat_reg;
    reg         pgm_reg;
    reg         erase_reg;
    reg         mass_reg;
    reg         high_voltage_enable_reg;
    reg  [15:0] addr_reg;
    reg  [7:0]  wdata_reg;
    reg  [15:0] lat_addr_reg;
    reg  [4:0]  state_reg;
    reg  [4:0]  state_next;
    reg         fail_reg;
    reg         refused_reg;
    reg         row_bad_reg;
    reg         prog_reg;
    reg         erase_page_reg;
    reg         erase_bulk_reg;

    // ***************************************************************
    // bus decode
    // ***************************************************************
    wire        acc;
    wire        wr;
    wire        rd;
    wire [15:0] idx;
    wire        hit_ctrl;
    wire        hit_stat;
    wire        hit_addr;
    wire        hit_data;
    wire        hit_prot;

    // access is taken once, in the cycle before ack rises
    assign acc      = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr       = acc && wb_we_i;
    assign rd       = acc && !wb_we_i;
    assign idx      = wb_adr_i[AW-1:2];
    assign hit_ctrl = (idx == `FPE_IDX_CTRL);
    assign hit_stat = (idx == `FPE_IDX_STAT);
    assign hit_addr = (idx == `FPE_IDX_ADDR);
    assign hit_data = (idx == `FPE_IDX_DATA);
    assign hit_prot = (idx == `FPE_IDX_PROT);

    wire wr_ctrl = wr && hit_ctrl && wb_sel_i[0];
    wire wr_stat = wr && hit_stat && wb_sel_i[0];
    wire wr_data = wr && hit_data && wb_sel_i[0];
    wire rd_prot = rd && hit_prot;

    // ***************************************************************
    // protection lookup on the latched target address
    // ***************************************************************
    wire any_prot;
    wire addr_prot;

    fpe_prot_chk #(
        .AW (16)
    ) u_prot (
        .prot_i      (prot_value_i),
        .addr_i      (lat_addr_reg),
        .any_prot_o  (any_prot),
        .addr_prot_o (addr_prot)
    );

    // ***************************************************************
    // control write decode
    // ***************************************************************
    wire new_pgm   = wb_dat_i[`FPE_CTRL_PGM];
    wire new_erase = wb_dat_i[`FPE_CTRL_ERASE];
    wire new_mass  = wb_dat_i[`FPE_CTRL_MASS];
    wire new_high_voltage_enable  = wb_dat_i[`FPE_CTRL_HIGH_VOLTAGE_ENABLE];

    // a write that would make both selects one keeps the old pair
    wire sel_ok    = !(new_pgm && new_erase);
    wire pgm_aft   = (wr_ctrl && sel_ok) ? new_pgm : pgm_reg;
    wire erase_aft = (wr_ctrl && sel_ok) ? new_erase : erase_reg;
    wire mass_aft  = wr_ctrl ? new_mass : mass_reg;

    // bulk erase needs the whole array open, others only the target
    wire hv_block  = (erase_aft && mass_aft) ? any_prot :
                     addr_prot;
    wire hv_allow  = (pgm_aft || erase_aft) &&
                     (state_reg == ST_LATCH) && !hv_block;
    wire hv_try    = wr_ctrl && new_high_voltage_enable && !high_voltage_enable_reg;
    wire hv_set    = hv_try && hv_allow;

    // ***************************************************************
    // array write classification
    // ***************************************************************
    wire any_sel   = pgm_reg || erase_reg;
    // one program cycle stays within the latched row
    wire same_row  = (addr_reg[15:ROW_LSB] ==
                      lat_addr_reg[15:ROW_LSB]);
    wire prog_wr   = wr_data && pgm_reg && high_voltage_enable_reg &&
                     (state_reg == ST_HV);

    // ***************************************************************
    // sequence state machine
    // ***************************************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (any_sel)
                    state_next = ST_SEL;
            end
            ST_SEL: begin
                if (!any_sel)
                    state_next = ST_IDLE;
                else if (rd_prot)
                    state_next = ST_ARMED;
            end
            ST_ARMED: begin
                if (!any_sel)
                    state_next = ST_IDLE;
                else if (wr_data)
                    state_next = ST_LATCH;
            end
            ST_LATCH: begin
                if (!any_sel)
                    state_next = ST_IDLE;
                else if (high_voltage_enable_reg)
                    state_next = ST_HV;
            end
            ST_HV: begin
                // selects may drop first; the cycle ends with the pump
                if (!high_voltage_enable_reg)
                    state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // other bus traffic leaves the state alone
    always @(posedge clk_i) begin
        if (rst_i)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // ***************************************************************
    // control register
    // ***************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            pgm_reg   <= 1'b0;
            erase_reg <= 1'b0;
            mass_reg  <= 1'b0;
            high_voltage_enable_reg  <= 1'b0;
        end else begin
            pgm_reg   <= pgm_aft;
            erase_reg <= erase_aft;
            mass_reg  <= mass_aft;
            if (wr_ctrl && !new_high_voltage_enable)
                high_voltage_enable_reg <= 1'b0;
            else if (hv_set)
                high_voltage_enable_reg <= 1'b1;
        end
    end

    // ***************************************************************
    // address, data and latched target
    // ***************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg     <= 16'h0000;
            wdata_reg    <= `FPE_ERASED_BYTE;
            lat_addr_reg <= 16'h0000;
        end else begin
            // a latched erase page must not move under the pump
            if (wr && hit_addr && !(erase_reg && |state_reg[4:3])) begin
                if (wb_sel_i[0])
                    addr_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    addr_reg[15:8] <= wb_dat_i[15:8];
            end
            if (wr_data)
                wdata_reg <= wb_dat_i[7:0];
            // the setup write fixes the page or row of the cycle
            if (wr_data && (state_reg == ST_ARMED))
                lat_addr_reg <= addr_reg;
        end
    end

    // ***************************************************************
    // status flags; a hardware set wins over a same-cycle clear
    // ***************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            fail_reg    <= 1'b0;
            refused_reg <= 1'b0;
            row_bad_reg <= 1'b0;
        end else begin
            if (prog_wr && (!same_row || row_bad_reg))
                fail_reg <= 1'b1;
            else if (wr_stat && wb_dat_i[`FPE_STAT_FAIL])
                fail_reg <= 1'b0;
            if (hv_try && !hv_allow)
                refused_reg <= 1'b1;
            else if (wr_stat && wb_dat_i[`FPE_STAT_REFUSED])
                refused_reg <= 1'b0;
            // once a cycle strays, the rest of it is dead
            if (state_reg == ST_IDLE)
                row_bad_reg <= 1'b0;
            else if (prog_wr && !same_row)
                row_bad_reg <= 1'b1;
        end
    end

    // ***************************************************************
    // array strobes
    // ***************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            prog_reg       <= 1'b0;
            erase_page_reg <= 1'b0;
            erase_bulk_reg <= 1'b0;
        end else begin
            // one pulse per byte; zero bits are driven low in the cell
            prog_reg       <= prog_wr && same_row &&
                              !row_bad_reg;
            // page erase clears the 64-byte page of the latched address
            erase_page_reg <= high_voltage_enable_reg && erase_reg && !mass_reg &&
                              (state_reg == ST_HV);
            erase_bulk_reg <= high_voltage_enable_reg && erase_reg && mass_reg &&
                              (state_reg == ST_HV);
        end
    end

    // ***************************************************************
    // bus answer; every access acked one cycle after request
    // ***************************************************************
    reg [31:0] rdat_next;

    always @* begin
        rdat_next = 32'h0000_0000;
        if (hit_ctrl) begin
            rdat_next[`FPE_CTRL_PGM]   = pgm_reg;
            rdat_next[`FPE_CTRL_ERASE] = erase_reg;
            rdat_next[`FPE_CTRL_MASS]  = mass_reg;
            rdat_next[`FPE_CTRL_HIGH_VOLTAGE_ENABLE]  = high_voltage_enable_reg;
        end else if (hit_stat) begin
            rdat_next[`FPE_STAT_FAIL]    = fail_reg;
            rdat_next[`FPE_STAT_REFUSED] = refused_reg;
            rdat_next[`FPE_STAT_STATE_LO+4:`FPE_STAT_STATE_LO] =
                state_reg;
        end else if (hit_addr) begin
            rdat_next[15:0] = addr_reg;
        end else if (hit_data) begin
            // array read; no recovery wait enforced here
            rdat_next[7:0] = fl_rdata_i;
        end else if (hit_prot) begin
            rdat_next[7:0] = prot_value_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= acc;
            if (rd)
                rdat_reg <= rdat_next;
        end
    end

    // ***************************************************************
    // outputs
    // ***************************************************************
    assign wb_ack_o        = ack_reg;
    assign wb_dat_o        = rdat_reg;
    assign fl_addr_o       = addr_reg;
    assign fl_wdata_o      = wdata_reg;
    assign fl_prog_o       = prog_reg;
    assign fl_erase_page_o = erase_page_reg;
    assign fl_erase_bulk_o = erase_bulk_reg;
    // pump runs exactly while the enable bit is one
    assign hv_en_o         = high_voltage_enable_reg;

endmodule // fpe_ctrl

// ---- rtl/fpe_defs.vh ----
// constants for the flash program/erase control block
// assumes a 32-bit classic wishbone slave port, registers on word indices
`ifndef FPE_DEFS_VH
`define FPE_DEFS_VH

// ***************************************************************
// register word indices (byte address = index * 4)
// ***************************************************************
`define FPE_IDX_CTRL      16'hFE08
`define FPE_IDX_STAT      16'hFE09
`define FPE_IDX_ADDR      16'hFE0A
`define FPE_IDX_DATA      16'hFE0B
`define FPE_IDX_PROT      16'hFF7E

// ***************************************************************
// control register fields
// ***************************************************************
`define FPE_CTRL_PGM      0
`define FPE_CTRL_ERASE    1
`define FPE_CTRL_MASS     2
`define FPE_CTRL_HIGH_VOLTAGE_ENABLE     3
`define FPE_CTRL_RESET    8'h00

// ***************************************************************
// status register fields
// ***************************************************************
`define FPE_STAT_FAIL     0
`define FPE_STAT_REFUSED  1
`define FPE_STAT_STATE_LO 2

// ***************************************************************
// array geometry and protection
// ***************************************************************
`define FPE_PAGE_BYTES    64
`define FPE_ROW_BYTES     32
`define FPE_PROT_NONE     8'hFF
`define FPE_PROT_ALL      8'h00
`define FPE_ERASED_BYTE   8'hFF

// ***************************************************************
// operator timing, for reference by software and bench
// ***************************************************************
`define FPE_CLK_MHZ       250
`define FPE_T_SETUP_US    10
`define FPE_T_PGS_US      5
`define FPE_T_HOLD_US     5
`define FPE_T_BHOLD_US    100
`define FPE_T_RCV_US      1
`define FPE_T_SETUP_CYC   (`FPE_T_SETUP_US * `FPE_CLK_MHZ)
`define FPE_T_HOLD_CYC    (`FPE_T_HOLD_US * `FPE_CLK_MHZ)

`endif

// ---- rtl/fpe_prot_chk.v ----
// protect range check for one flash address
// assumes a 16-bit address map with the array in the top quarter
`timescale 1ns/1ps
`include "fpe_defs.vh"

module fpe_prot_chk #(
    parameter AW = 16
) (
    input  wire [7:0]    prot_i,
    input  wire [AW-1:0] addr_i,
    output wire          any_prot_o,
    output wire          addr_prot_o
);

    // ***************************************************************
    // protected range runs from the start address to the top
    // ***************************************************************
    wire [AW-1:0] start_addr;

    // start = 2'b11, protect byte, six zero bits (page aligned)
    assign start_addr  = {2'b11, prot_i, 6'h00};
    assign any_prot_o  = (prot_i != `FPE_PROT_NONE);
    assign addr_prot_o = any_prot_o &&
                         ((prot_i == `FPE_PROT_ALL) ||
                          (addr_i >= start_addr));

endmodule // fpe_prot_chk

// ---- sim/fpe_flash_model.sv ----
// behavioural array and charge pump on the far side of fpe_ctrl
// assumes one clock; the bench drives the protect byte through prot_i
`timescale 1ns/1ps
`include "fpe_defs.vh"

module fpe_flash_model (
    input  wire        clk_i,
    input  wire [7:0]  prot_i,
    input  wire [15:0] fl_addr_i,
    input  wire [7:0]  fl_wdata_i,
    input  wire        fl_prog_i,
    input  wire        fl_erase_page_i,
    input  wire        fl_erase_bulk_i,
    input  wire        hv_en_i,
    output wire [7:0]  rdata_o,
    output wire [7:0]  prot_o
);
    // ************************************************************
    // array contents
    // ************************************************************
    logic [7:0] mem_reg [0:65535];
    integer     k;

    initial begin
        for (k = 0; k < 65536; k++) begin
            mem_reg[k] = `FPE_ERASED_BYTE;
        end
    end

    // nothing changes without the pump: every path is gated by hv_en_i
    always @(posedge clk_i) begin
        if (hv_en_i && fl_erase_bulk_i) begin
            for (k = 0; k < 65536; k++) begin
                mem_reg[k] <= `FPE_ERASED_BYTE;
            end
        end else if (hv_en_i && fl_erase_page_i) begin
            for (k = 0; k < `FPE_PAGE_BYTES; k++) begin
                mem_reg[{fl_addr_i[15:6], k[5:0]}] <= `FPE_ERASED_BYTE;
            end
        end else if (hv_en_i && fl_prog_i) begin
            // programming can only clear bits
            mem_reg[fl_addr_i] <= mem_reg[fl_addr_i] & fl_wdata_i;
        end
    end

    assign rdata_o = mem_reg[fl_addr_i];
    assign prot_o  = prot_i;
endmodule // fpe_flash_model

// ---- sim/fpe_ctrl_chk.sv ----
// port assertions for the flash program/erase sequencer
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
`include "fpe_defs.vh"

module fpe_ctrl_chk #(
    parameter AW = 18
) (
    input wire          clk_i,
    input wire          rst_i,
    input wire          wb_cyc_i,
    input wire          wb_stb_i,
    input wire          wb_we_i,
    input wire [AW-1:0] wb_adr_i,
    input wire [3:0]    wb_sel_i,
    input wire [31:0]   wb_dat_i,
    input wire [31:0]   wb_dat_o,
    input wire          wb_ack_o,
    input wire [7:0]    prot_value_i,
    input wire [7:0]    fl_rdata_i,
    input wire [15:0]   fl_addr_o,
    input wire [7:0]    fl_wdata_o,
    input wire          fl_prog_o,
    input wire          fl_erase_page_o,
    input wire          fl_erase_bulk_o,
    input wire          hv_en_o
);
    // ************************************************************
    // helper logic
    // ************************************************************
    wire       hv_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                       wb_adr_i[17:2] == `FPE_IDX_CTRL && wb_dat_i[3];
    reg [10:0] row_reg;
    reg        row_vld_reg;

    // every program pulse records its row; the first of a high-voltage period arms the check
    always @(posedge clk_i) begin
        if (rst_i || !hv_en_o) begin
            row_vld_reg <= 1'b0;
        end else if (fl_prog_o) begin
            row_vld_reg <= 1'b1;
        end
        if (fl_prog_o) begin
            row_reg <= fl_addr_o[15:5];
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_follows_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
        |=> wb_ack_o) else $error("no ack after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
        (!hv_en_o && !fl_prog_o && !fl_erase_page_o && !fl_erase_bulk_o))
        else $error("outputs not cleared by reset");
    hv_cause_a: assert property ($rose(hv_en_o) |->
        ($past(hv_wr) || $past(hv_wr, 2))) else $error("pump rose unasked");
    prog_hv_a: assert property (fl_prog_o |-> hv_en_o)
        else $error("program strobe without pump");
    erase_hv_a: assert property ((fl_erase_page_o || fl_erase_bulk_o)
        |-> $past(hv_en_o)) else $error("erase without pump");
    erase_excl_a: assert property (!(fl_erase_page_o && fl_erase_bulk_o))
        else $error("page and bulk erase together");
    op_excl_a: assert property (fl_prog_o |->
        !(fl_erase_page_o || fl_erase_bulk_o)) else $error("program in erase");
    bulk_prot_a: assert property ($rose(fl_erase_bulk_o) |->
        prot_value_i == `FPE_PROT_NONE) else $error("bulk erase protected");
    prog_prot_a: assert property (fl_prog_o |->
        (prot_value_i == 8'hFF || (prot_value_i != 8'h00 &&
        fl_addr_o < {2'b11, prot_value_i, 6'h00}))) else $error("protected");
    prog_row_a: assert property ((fl_prog_o && row_vld_reg) |->
        fl_addr_o[15:5] == row_reg) else $error("program left its row");

    cover property (fl_prog_o);
    cover property ($rose(fl_erase_page_o));
    cover property ($rose(fl_erase_bulk_o));
endmodule // fpe_ctrl_chk

bind fpe_ctrl fpe_ctrl_chk #(.AW(AW)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .prot_value_i(prot_value_i), .fl_rdata_i(fl_rdata_i),
    .fl_addr_o(fl_addr_o), .fl_wdata_o(fl_wdata_o), .fl_prog_o(fl_prog_o),
    .fl_erase_page_o(fl_erase_page_o), .fl_erase_bulk_o(fl_erase_bulk_o),
    .hv_en_o(hv_en_o)
);

// ---- sim/tb_top.sv ----
// self-checking bench for the flash program/erase sequencer
// assumes fpe_ctrl, the array model and the bound checker are compiled
`timescale 1ns/1ps
`include "fpe_defs.vh"

module tb_top;
    // ************************************************************
    // signals
    // ************************************************************
    typedef struct {
        string       nm;
        logic [31:0] v;
    } fpe_note_t;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [17:0] wb_adr_i;
    logic [31:0] wb_dat_i;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o;
    logic [7:0]  prot_reg;
    wire  [7:0]  prot_value;
    wire  [7:0]  fl_rdata;
    wire  [15:0] fl_addr;
    wire  [7:0]  fl_wdata;
    wire         fl_prog;
    wire         fl_erase_page;
    wire         fl_erase_bulk;
    wire         hv_en;
    fpe_note_t   rdq[$];
    logic [7:0]  shadow[logic [15:0]];
    integer      errors;
    integer      check_count;
    integer      seed;
    int          i;

    fpe_ctrl #(.AW(18)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .prot_value_i(prot_value),
        .fl_rdata_i(fl_rdata), .fl_addr_o(fl_addr), .fl_wdata_o(fl_wdata),
        .fl_prog_o(fl_prog), .fl_erase_page_o(fl_erase_page),
        .fl_erase_bulk_o(fl_erase_bulk), .hv_en_o(hv_en)
    );
    fpe_flash_model i_array (
        .clk_i(clk_i), .prot_i(prot_reg), .fl_addr_i(fl_addr),
        .fl_wdata_i(fl_wdata), .fl_prog_i(fl_prog),
        .fl_erase_page_i(fl_erase_page), .fl_erase_bulk_i(fl_erase_bulk),
        .hv_en_i(hv_en), .rdata_o(fl_rdata), .prot_o(prot_value)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ************************************************************
    // checking and bus tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // no latency assumed: waits for ack under a bounded count
    task automatic bus(input logic we, input logic [15:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 20) chk("ack", {31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        rdq.push_back('{$sformatf("reg %h", idx), exp});
        bus(1'b0, idx, 32'h0);
    endtask

    // read results are compared in order as their acks appear
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rdq.size() > 0) begin
            chk(rdq[0].nm, wb_dat_o, rdq[0].v);
            void'(rdq.pop_front());
        end
    end

    task automatic rd_byte(input logic [15:0] a);
        wr(`FPE_IDX_ADDR, {16'h0, a});
        rd(`FPE_IDX_DATA, {24'h0, shadow.exists(a) ? shadow[a] : 8'hFF});
    endtask

    // ************************************************************
    // sequences
    // ************************************************************
    task automatic prog_row(input logic [15:0] a, input int nb,
                            input logic ok, input logic xrow);
        logic [7:0] d;
        int         j;
        wr(`FPE_IDX_CTRL, 32'h1);
        rd(`FPE_IDX_PROT, {24'h0, prot_reg});
        wr(`FPE_IDX_ADDR, {16'h0, a});
        wr(`FPE_IDX_DATA, 32'h0);
        wr(`FPE_IDX_CTRL, 32'h9);
        rd(`FPE_IDX_CTRL, ok ? 32'h9 : 32'h1);
        for (j = 0; j < nb; j++) begin
            d = $random(seed);
            if (ok) shadow[a + j[15:0]] = d;
            wr(`FPE_IDX_ADDR, {16'h0, a + j[15:0]});
            wr(`FPE_IDX_DATA, {24'h0, d});
        end
        if (xrow) begin
            wr(`FPE_IDX_ADDR, {16'h0, a + 16'h0020});
            wr(`FPE_IDX_DATA, 32'h0);
        end
        wr(`FPE_IDX_CTRL, 32'h8);
        wr(`FPE_IDX_CTRL, 32'h0);
        rd(`FPE_IDX_STAT, {30'h0, ~ok, xrow} | 32'h4);
        wr(`FPE_IDX_STAT, 32'h3);
        for (j = 0; j < nb + 33; j++) rd_byte(a + j[15:0]);
    endtask

    task automatic erase(input logic [31:0] sel, input logic [15:0] a,
                         input logic ok);
        int j;
        wr(`FPE_IDX_CTRL, sel);
        rd(16'h0100, 32'h0);
        rd(`FPE_IDX_PROT, {24'h0, prot_reg});
        wr(`FPE_IDX_ADDR, {16'h0, a});
        wr(`FPE_IDX_DATA, $random(seed));
        wr(`FPE_IDX_CTRL, sel | 32'h8);
        rd(`FPE_IDX_CTRL, ok ? (sel | 32'h8) : sel);
        wr(`FPE_IDX_CTRL, 32'h8);
        wr(`FPE_IDX_CTRL, 32'h0);
        rd(`FPE_IDX_STAT, ok ? 32'h4 : 32'h6);
        wr(`FPE_IDX_STAT, 32'h3);
        if (ok && sel[2]) shadow.delete();
        for (j = 0; j < 64 && ok && !sel[2]; j++) shadow.delete({a[15:6], j[5:0]});
    endtask

    initial begin
        errors = 0;
        check_count = 0;
        seed = 32'hBB3A1536;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 18'h0;
        wb_dat_i = 32'h0;
        prot_reg = 8'hFF;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`FPE_IDX_CTRL, 32'h0);
        rd(`FPE_IDX_STAT, 32'h4);
        wr(16'h0123, 32'hFFFFFFFF);
        rd(16'h0123, 32'h0);
        wr(`FPE_IDX_CTRL, 32'h3);
        rd(`FPE_IDX_CTRL, 32'h0);
        wr(`FPE_IDX_CTRL, 32'h1);
        wr(`FPE_IDX_CTRL, 32'h3);
        rd(`FPE_IDX_CTRL, 32'h1);
        wr(`FPE_IDX_CTRL, 32'h9);
        rd(`FPE_IDX_CTRL, 32'h1);
        wr(`FPE_IDX_CTRL, 32'h0);
        wr(`FPE_IDX_CTRL, 32'h8);
        rd(`FPE_IDX_CTRL, 32'h0);
        rd(`FPE_IDX_STAT, 32'h6);
        wr(`FPE_IDX_STAT, 32'h2);
        rd(`FPE_IDX_STAT, 32'h4);
        prog_row(16'hE040, 8, 1'b1, 1'b0);
        prog_row(16'hE080, 2, 1'b1, 1'b1);
        erase(32'h2, 16'hE045, 1'b1);
        for (i = 0; i < 128; i++) rd_byte(16'hE040 + i[15:0]);
        prot_reg <= 8'hF0;
        prog_row(16'hFD00, 2, 1'b0, 1'b0);
        erase(32'h6, 16'hE000, 1'b0);
        prot_reg <= 8'h00;
        prog_row(16'hE0C0, 1, 1'b0, 1'b0);
        prot_reg <= 8'hFF;
        erase(32'h6, 16'hE000, 1'b1);
        rd_byte(16'hE080);
        repeat (4) @(posedge clk_i);
        results();
    end

    // whole run needs about two thousand cycles
    initial begin
        repeat (30000) @(posedge clk_i);
        chk("watchdog", 32'h1, 32'h0);
        results();
    end
endmodule // tb_top
